/* File: design/sio_flag_if.sv */
`timescale 1ns/1ps
// Flags and enables passed to the request encoder
interface sir_flag_if;
	logic [3:0] flags;
	logic       rx_en;
	logic       tx_en;
	logic [3:0] req;
	logic       any;
	logic [1:0] top;
	modport src (output flags, output rx_en, output tx_en, input req, input any, input top);
	modport enc (input flags, input rx_en, input tx_en, output req, output any, output top);
endinterface

/* File: design/sio_irq.sv */
`timescale 1ns/1ps
// Operation
// - Four separate request outputs per channel
// - Data requests gated by enable bits
// - Overrun requests never gated
// - Receive full flag raises its request
// - Transmit empty flag raises its request
// - Receive overrun flag raises its request
// - Transmit overrun flag raises its request
// - Priority: rx overrun, tx overrun, rx full, tx empty
// - Sync enable: 1 interval, 0 continuous
// - Both start sources with both modes
// - Receive complete sets receive full flag
// - Load, transmit disable or reset set empty
// - Receive while still full sets overrun
// - Transmit start while empty sets overrun
module sir_irq (
	input  wire logic       sys_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       clk_en_in,
	input  wire logic       receive_irq_enable_in,
	input  wire logic       transmit_irq_enable_in,
	input  wire logic       receive_enable_in,
	input  wire logic       transmit_enable_in,
	input  wire logic       sync_every_word_in,
	input  wire logic       transmit_start_source_in,
	input  wire logic       rx_done_in,
	input  wire logic       tx_load_in,
	input  wire logic       tx_start_in,
	input  wire logic [3:0] flag_clear_in,
	output logic [3:0]      status_out,
	output logic            receive_full_request_out,
	output logic            transmit_empty_request_out,
	output logic            receive_overrun_request_out,
	output logic            transmit_overrun_request_out,
	output logic            request_any_out,
	output logic [1:0]      request_top_out,
	output logic            interval_mode_out,
	output logic            start_internal_out
);
	logic [3:0] flags_q;
	logic [3:0] flags_d;
	logic       mode_q;
	logic       src_q;
	wire        set_rx_full;
	wire        set_tx_empty;
	wire        set_rx_ovr;
	wire        set_tx_ovr;
	wire        clr_rx_full;
	wire        tx_dis_edge;
	logic       tx_en_q;
	sir_flag_if fi ();

	assign set_rx_full  = rx_done_in & receive_enable_in;
	assign set_rx_ovr   = set_rx_full & flags_q[sir_pkg::RX_FULL_BIT];
	assign tx_dis_edge  = tx_en_q & ~transmit_enable_in;
	assign set_tx_empty = tx_load_in | tx_dis_edge;
	assign set_tx_ovr   = tx_start_in & transmit_enable_in & flags_q[sir_pkg::TX_EMPTY_BIT];
	assign clr_rx_full  = flag_clear_in[sir_pkg::RX_FULL_BIT] | ~receive_enable_in;

	// Next flag values, set wins over clear
	always_comb begin
		flags_d = flags_q;
		if (clr_rx_full) begin
			flags_d[sir_pkg::RX_FULL_BIT] = 1'b0;
		end
		if (set_rx_full) begin
			flags_d[sir_pkg::RX_FULL_BIT] = 1'b1;
		end
		if (flag_clear_in[sir_pkg::TX_EMPTY_BIT]) begin
			flags_d[sir_pkg::TX_EMPTY_BIT] = 1'b0;
		end
		if (set_tx_empty) begin
			flags_d[sir_pkg::TX_EMPTY_BIT] = 1'b1;
		end
		if (flag_clear_in[sir_pkg::RX_OVERRUN_BIT]) begin
			flags_d[sir_pkg::RX_OVERRUN_BIT] = 1'b0;
		end
		if (set_rx_ovr) begin
			flags_d[sir_pkg::RX_OVERRUN_BIT] = 1'b1;
		end
		if (flag_clear_in[sir_pkg::TX_OVERRUN_BIT]) begin
			flags_d[sir_pkg::TX_OVERRUN_BIT] = 1'b0;
		end
		if (set_tx_ovr) begin
			flags_d[sir_pkg::TX_OVERRUN_BIT] = 1'b1;
		end
	end

	// Flag and mode registers
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flags_q <= sir_pkg::STATUS_RESET;
			tx_en_q <= 1'b0;
			mode_q  <= 1'b0;
			src_q   <= 1'b0;
		end else if (clk_en_in) begin
			flags_q <= flags_d;
			tx_en_q <= transmit_enable_in;
			mode_q  <= sync_every_word_in;
			src_q   <= transmit_start_source_in;
		end
	end

	// Encoder hookup
	assign fi.flags = flags_q;
	assign fi.rx_en = receive_irq_enable_in;
	assign fi.tx_en = transmit_irq_enable_in;
	sir_req_enc u_enc (
		.f (fi)
	);

	assign receive_full_request_out     = fi.req[sir_pkg::RX_FULL_BIT];
	assign transmit_empty_request_out   = fi.req[sir_pkg::TX_EMPTY_BIT];
	assign receive_overrun_request_out  = fi.req[sir_pkg::RX_OVERRUN_BIT];
	assign transmit_overrun_request_out = fi.req[sir_pkg::TX_OVERRUN_BIT];
	assign request_any_out   = fi.any;
	assign request_top_out   = fi.top;
	assign status_out        = flags_q;
	assign interval_mode_out = mode_q;
	assign start_internal_out = src_q;

	property p_rx_gate;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		receive_full_request_out == (flags_q[0] & receive_irq_enable_in);
	endproperty
	a_rx_gate: assert property (p_rx_gate) else $error("rx full gating wrong");
	property p_tx_gate;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		transmit_empty_request_out == (flags_q[1] & transmit_irq_enable_in);
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("tx empty gating wrong");
	property p_ovr;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		flags_q[2] |-> receive_overrun_request_out;
	endproperty
	a_ovr: assert property (p_ovr) else $error("rx overrun request missing");
	property p_tovr;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		flags_q[3] |-> transmit_overrun_request_out;
	endproperty
	a_tovr: assert property (p_tovr) else $error("tx overrun request missing");
	property p_rx_set;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		clk_en_in && set_rx_full |=> flags_q[0];
	endproperty
	a_rx_set: assert property (p_rx_set) else $error("rx full not set");
	property p_rx_ovr;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		clk_en_in && rx_done_in && receive_enable_in && flags_q[0] |=> flags_q[2];
	endproperty
	a_rx_ovr: assert property (p_rx_ovr) else $error("rx overrun not set");
	property p_tx_dis;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		clk_en_in && $fell(transmit_enable_in) |=> flags_q[1];
	endproperty
	a_tx_dis: assert property (p_tx_dis) else $error("tx empty not set on disable");
	property p_tx_ovr;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		clk_en_in && tx_start_in && transmit_enable_in && flags_q[1] |=> flags_q[3];
	endproperty
	a_tx_ovr: assert property (p_tx_ovr) else $error("tx overrun not set");
	property p_pri;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		receive_overrun_request_out |-> request_top_out == 2'h0;
	endproperty
	a_pri: assert property (p_pri) else $error("priority order wrong");
	property p_level;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		receive_overrun_request_out && !flag_clear_in[2] && clk_en_in
			|=> receive_overrun_request_out;
	endproperty
	a_level: assert property (p_level) else $error("request dropped early");
	property p_tx_load;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		clk_en_in && tx_load_in |=> flags_q[sir_pkg::TX_EMPTY_BIT];
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("tx empty not set on load");
	property p_rx_off;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		clk_en_in && !receive_enable_in |=> !flags_q[sir_pkg::RX_FULL_BIT];
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("rx full kept while disabled");
	property p_rx_req;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		flags_q[sir_pkg::RX_FULL_BIT] && receive_irq_enable_in |-> receive_full_request_out;
	endproperty
	a_rx_req: assert property (p_rx_req) else $error("rx full request missing");
	property p_tx_req;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		flags_q[sir_pkg::TX_EMPTY_BIT] && transmit_irq_enable_in |-> transmit_empty_request_out;
	endproperty
	a_tx_req: assert property (p_tx_req) else $error("tx empty request missing");
	property p_pri_tovr;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		!receive_overrun_request_out && transmit_overrun_request_out
			|-> request_top_out == sir_pkg::PRI_TX_OVERRUN;
	endproperty
	a_pri_tovr: assert property (p_pri_tovr) else $error("tx overrun rank wrong");
	property p_pri_rfull;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		!receive_overrun_request_out && !transmit_overrun_request_out && receive_full_request_out
			|-> request_top_out == sir_pkg::PRI_RX_FULL;
	endproperty
	a_pri_rfull: assert property (p_pri_rfull) else $error("rx full rank wrong");
	property p_any;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		request_any_out == (receive_full_request_out | transmit_empty_request_out
			| receive_overrun_request_out | transmit_overrun_request_out);
	endproperty
	a_any: assert property (p_any) else $error("request summary wrong");
	property p_tlevel;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		transmit_overrun_request_out && !flag_clear_in[sir_pkg::TX_OVERRUN_BIT] && clk_en_in
			|=> transmit_overrun_request_out;
	endproperty
	a_tlevel: assert property (p_tlevel) else $error("tx overrun dropped early");
	property p_freeze;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		!clk_en_in |=> $stable(flags_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("flags moved while frozen");
	property p_mode;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		clk_en_in |=> interval_mode_out == $past(sync_every_word_in);
	endproperty
	a_mode: assert property (p_mode) else $error("framing mode not taken");
	property p_src;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		clk_en_in |=> start_internal_out == $past(transmit_start_source_in);
	endproperty
	a_src: assert property (p_src) else $error("start source not taken");
endmodule // sir_irq

/* File: design/sio_pkg.sv */
// Shared constants for the serial channel interrupt block
package sir_pkg;
	// Status flag bit positions
	localparam int RX_FULL_BIT    = 0;
	localparam int TX_EMPTY_BIT   = 1;
	localparam int RX_OVERRUN_BIT = 2;
	localparam int TX_OVERRUN_BIT = 3;
	localparam int FLAG_W         = 4;
	// Reset value of the status flags: only transmit empty set
	localparam logic [3:0] STATUS_RESET = 4'h2;
	// Request priority codes, 0 is highest
	localparam logic [1:0] PRI_RX_OVERRUN = 2'h0;
	localparam logic [1:0] PRI_TX_OVERRUN = 2'h1;
	localparam logic [1:0] PRI_RX_FULL    = 2'h2;
	localparam logic [1:0] PRI_TX_EMPTY   = 2'h3;
	// Framing modes
	typedef enum logic {FRAME_CONTINUOUS, FRAME_INTERVAL} sir_frame_type;
endpackage

/* File: design/sio_req_enc.sv */
`timescale 1ns/1ps
// Gates flags into requests and picks the highest pending one
module sir_req_enc (
	sir_flag_if.enc f
);
	wire rx_full_req;
	wire tx_empty_req;
	assign rx_full_req  = f.flags[sir_pkg::RX_FULL_BIT] & f.rx_en;
	assign tx_empty_req = f.flags[sir_pkg::TX_EMPTY_BIT] & f.tx_en;
	assign f.req = {f.flags[sir_pkg::TX_OVERRUN_BIT], f.flags[sir_pkg::RX_OVERRUN_BIT],
		tx_empty_req, rx_full_req};
	// Any request pending
	assign f.any = |f.req;
	assign f.top = f.req[sir_pkg::RX_OVERRUN_BIT] ? sir_pkg::PRI_RX_OVERRUN :
		f.req[sir_pkg::TX_OVERRUN_BIT] ? sir_pkg::PRI_TX_OVERRUN :
		f.req[sir_pkg::RX_FULL_BIT] ? sir_pkg::PRI_RX_FULL : sir_pkg::PRI_TX_EMPTY;
endmodule // sir_req_enc

/* File: sim/sio_interrupt_controller_model.sv */
`timescale 1ns/1ps
// Interrupt controller stand-in for one serial channel
module sir_ctrl_model #(
	parameter logic [3:0] CHANNEL_LEVEL = 4'h5
) (
	input  wire logic [3:0] req_in,
	output logic [3:0]      level_out
);
	// Whole channel level
	// One level for the channel, whichever of its four sources asks
	assign level_out = (|req_in) ? CHANNEL_LEVEL : 4'h0;
endmodule // sir_ctrl_model

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic       sys_clk_in      = 1'b0;
	logic       rst_n_in        = 1'b0;
	logic [6:0] ctl             = 7'h6C; // clk_en rx_ie tx_ie rx_en tx_en sync src
	logic [2:0] ev              = 3'h0;  // rx_done tx_load tx_start
	logic [3:0] clr             = 4'h0;
	logic [3:0] status, lvl;
	wire  [3:0] req;
	logic       any, imode, sint;
	logic [1:0] top;
	int         n_fail          = 0;
	int         samples_checked = 0;
	int         i;
	logic [1:0] order [4]       = '{2'h2, 2'h3, 2'h0, 2'h1};
	logic [1:0] tops [4]        = '{2'h1, 2'h2, 2'h3, 2'h3};
	logic [3:0] stat [4]        = '{4'hB, 4'h3, 4'h2, 4'h0};

	// Clock generator
	always #12.5 sys_clk_in = ~sys_clk_in;

	sir_irq DUT (
		.sys_clk_in                  (sys_clk_in),
		.rst_n_in                    (rst_n_in),
		.clk_en_in                   (ctl[6]),
		.receive_irq_enable_in       (ctl[5]),
		.transmit_irq_enable_in      (ctl[4]),
		.receive_enable_in           (ctl[3]),
		.transmit_enable_in          (ctl[2]),
		.sync_every_word_in          (ctl[1]),
		.transmit_start_source_in    (ctl[0]),
		.rx_done_in                  (ev[2]),
		.tx_load_in                  (ev[1]),
		.tx_start_in                 (ev[0]),
		.flag_clear_in               (clr),
		.status_out                  (status),
		.receive_full_request_out    (req[0]),
		.transmit_empty_request_out  (req[1]),
		.receive_overrun_request_out (req[2]),
		.transmit_overrun_request_out(req[3]),
		.request_any_out             (any),
		.request_top_out             (top),
		.interval_mode_out           (imode),
		.start_internal_out          (sint)
	);

	sir_ctrl_model irq_ctrl (
		.req_in   (req),
		.level_out(lvl)
	);

	// Compare and count
	task chk(input string name, input logic [3:0] exp, input logic [3:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Controls and one-cycle events at an edge, result settled after the next
	task pulse(input logic [6:0] c, input logic [2:0] e, input logic [3:0] k);
		@(posedge sys_clk_in);
		ctl <= c;
		ev  <= e;
		clr <= k;
		@(posedge sys_clk_in);
		ev  <= 3'h0;
		clr <= 4'h0;
		#1;
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		pulse(7'h6C, 3'h0, 4'h0);
		chk("status", 4'h2, status);
		chk("tx_empty_req", 4'h0, {3'h0, req[1]});
		pulse(7'h7C, 3'h4, 4'h0);
		chk("status", 4'h3, status);
		chk("requests", 4'h3, req);
		pulse(7'h7C, 3'h4, 4'h1);
		chk("status", 4'h7, status);
		pulse(7'h4C, 3'h1, 4'h0);
		chk("status", 4'hF, status);
		chk("requests", 4'hC, req);
		chk("top", 4'h0, {2'h0, top});
		chk("any", 4'h1, {3'h0, any});
		chk("level", 4'h5, lvl);
		for (i = 0; i < 4; i++) begin
			pulse(7'h7C, 3'h0, 4'h1 << order[i]);
			chk("top", {2'h0, tops[i]}, {2'h0, top});
			chk("requests", stat[i], req);
		end
		chk("any", 4'h0, {3'h0, any});
		chk("level", 4'h0, lvl);
		pulse(7'h7C, 3'h2, 4'h0);
		chk("status", 4'h2, status);
		chk("requests", 4'h2, req);
		pulse(7'h7C, 3'h0, 4'h2);
		chk("status", 4'h0, status);
		pulse(7'h78, 3'h0, 4'h0);
		chk("status", 4'h2, status);
		pulse(7'h78, 3'h0, 4'h0);
		chk("status", 4'h2, status);
		pulse(7'h7C, 3'h4, 4'h2);
		chk("status", 4'h1, status);
		pulse(7'h7C, 3'h1, 4'h0);
		chk("status", 4'h1, status);
		pulse(7'h74, 3'h4, 4'h0);
		chk("status", 4'h0, status);
		pulse(7'h3C, 3'h4, 4'h0);
		chk("status", 4'h0, status);
		for (i = 0; i < 4; i++) begin
			pulse({5'h1F, i[1:0]}, 3'h0, 4'h0);
			chk("mode", {2'h0, i[1:0]}, {2'h0, imode, sint});
		end
		// Second reset in mid-run with a flag and both modes set
		pulse(7'h7F, 3'h4, 4'h0);
		chk("status", 4'h1, status);
		@(posedge sys_clk_in);
		rst_n_in <= 1'b0;
		@(posedge sys_clk_in);
		#1;
		chk("status", 4'h2, status);
		chk("mode", 4'h0, {2'h0, imode, sint});
		chk("requests", 4'h2, req);
		@(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		pulse(7'h7C, 3'h4, 4'h0);
		chk("status", 4'h3, status);
		final_report();
	end

	// Watchdog against a hang
	initial begin
		#20000;
		n_fail++;
		final_report();
	end
endmodule // testbench
